// ### sccs_clock_ctrl.sv
// System clock source selection, division, flash power-down and failure detection.
// Assumes oscillator levels arrive on pins asynchronous to clk and option bits are static.
`timescale 1ns/1ps
`include "sccs_defines.svh"
module sccs_clock_ctrl
#(
   parameter int PRIM_FAIL_CYC = `SCCS_PRIM_FAIL_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xin,
   input wire logic ipo_clk,
   input wire logic wdt_clk,
   input wire logic [1:0] opt_osc_mode,
   input wire logic [7:0] opt_trim,
   input wire logic opt_lp_n,
   output logic sys_clk_o,
   output logic [7:0] ipo_trim,
   output logic ipo_en,
   output logic xtal_en,
   output logic wdt_en,
   output logic [1:0] xtal_drive,
   output logic flash_pd,
   output logic irq
);
   logic xin_lvl, xin_rise, ipo_lvl, ipo_rise, wdt_lvl, wdt_rise;
   logic [7:0] ctl_q, div_q, trim_q;
   logic [1:0] stat_q, mask_q;
   sccs_pkg::sccs_lock_e lock_q;
   sccs_pkg::sccs_src_e cur_q, prog_src, tgt_src;
   sccs_pkg::sccs_mode_e mode;
   logic rc_half_q, root_q, sys_clk_q, failover_q, wdt_dead_q, slow_q, flash_pd_q;
   logic sys_prev_q;
   logic [7:0] div_cnt_q, div_cnt_d;
   logic [19:0] pf_cnt_q;
   logic [13:0] wf_cnt_q;
   logic [7:0] per_cnt_q;
   logic ctl_wr, apb_wr, apb_setup, pf_event, wf_event, root_d, root_rise, sys_rise, xtal_lvl;
   logic prog_rise;
   logic [31:0] rd_d, prdata_q;
   logic err_d, pslverr_q;

   // One synchroniser per oscillator pin; all three are free running asynchronous levels.
   sccs_edge_sync u_sync_xin (.clk(clk), .sys_rst(sys_rst), .async_in(xin),
                              .lvl(xin_lvl), .rise(xin_rise));
   sccs_edge_sync u_sync_ipo (.clk(clk), .sys_rst(sys_rst), .async_in(ipo_clk),
                              .lvl(ipo_lvl), .rise(ipo_rise));
   sccs_edge_sync u_sync_wdt (.clk(clk), .sys_rst(sys_rst), .async_in(wdt_clk),
                              .lvl(wdt_lvl), .rise(wdt_rise));

   // Oscillator mode straight from option bits; it sets the crystal drive strength.
   assign mode = sccs_pkg::sccs_mode_e'(opt_osc_mode);
   assign xtal_drive = opt_osc_mode;

   // Source decode of the select field; the reserved code falls back to the precision oscillator.
   always_comb
   begin
      if (ctl_q[1:0] == `SCCS_SEL_XTAL)
      begin
         prog_src = sccs_pkg::SCCS_SRC_XTAL;
      end
      else if (ctl_q[1:0] == `SCCS_SEL_WDT)
      begin
         prog_src = sccs_pkg::SCCS_SRC_WDT;
      end
      else
      begin
         prog_src = sccs_pkg::SCCS_SRC_IPO;
      end
   end
   assign tgt_src = failover_q ? sccs_pkg::SCCS_SRC_WDT : prog_src;

   // APB decode; the slave never waits, so pready is always high.
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite;
   assign ctl_wr = apb_wr && (paddr == `SCCS_ADDR_CTL);
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // Read mux; unmapped addresses read zero and report an error.
   always_comb
   begin
      rd_d = 32'h00000000;
      err_d = 1'b0;
      if (paddr == `SCCS_ADDR_CTL)
      begin
         rd_d[7:0] = ctl_q;
      end
      else if (paddr == `SCCS_ADDR_DIV)
      begin
         rd_d[7:0] = div_q;
      end
      else if (paddr == `SCCS_ADDR_TRIM)
      begin
         rd_d[7:0] = trim_q;
      end
      else if (paddr == `SCCS_ADDR_STAT)
      begin
         rd_d[1:0] = stat_q;
      end
      else if (paddr == `SCCS_ADDR_MASK)
      begin
         rd_d[1:0] = mask_q;
      end
      else if (paddr == `SCCS_ADDR_INFO)
      begin
         rd_d[7:0] = {wdt_dead_q, failover_q, slow_q, 1'b0, opt_osc_mode, cur_q};
      end
      else
      begin
         err_d = 1'b1;
      end
   end

   // Read data and error are captured in the setup cycle and stand through the access.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else if (apb_setup)
      begin
         prdata_q <= pwrite ? 32'h00000000 : rd_d;
         pslverr_q <= err_d;
      end
   end

   // Unlock walk: a wrong value restarts it, a repeated first key keeps the first step.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         lock_q <= sccs_pkg::SCCS_LK_LOCKED;
      end
      else if (ctl_wr)
      begin
         case (lock_q)
            sccs_pkg::SCCS_LK_LOCKED:
               lock_q <= (pwdata[7:0] == `SCCS_UNLOCK_1) ? sccs_pkg::SCCS_LK_KEY1
                                                         : sccs_pkg::SCCS_LK_LOCKED;
            sccs_pkg::SCCS_LK_KEY1:
               if (pwdata[7:0] == `SCCS_UNLOCK_2)
               begin
                  lock_q <= sccs_pkg::SCCS_LK_OPEN;
               end
               else if (pwdata[7:0] != `SCCS_UNLOCK_1)
               begin
                  lock_q <= sccs_pkg::SCCS_LK_LOCKED;
               end
            default:
               lock_q <= sccs_pkg::SCCS_LK_LOCKED;
         endcase
      end
   end

   // Control, divider and trim; reset values follow the low power and trim options.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctl_q <= `SCCS_CTL_RST | {5'h00, ~opt_lp_n, 2'h0};
         div_q <= opt_lp_n ? `SCCS_DIV_RST : `SCCS_DIV_LP;
         trim_q <= opt_trim;
      end
      else
      begin
         if (ctl_wr && lock_q == sccs_pkg::SCCS_LK_OPEN)
         begin
            ctl_q <= pwdata[7:0];
         end
         if (apb_wr && paddr == `SCCS_ADDR_DIV)
         begin
            div_q <= pwdata[7:0];
         end
         if (apb_wr && paddr == `SCCS_ADDR_TRIM)
         begin
            trim_q <= pwdata[7:0];
         end
      end
   end
   assign ipo_trim = trim_q;
   assign ipo_en = ctl_q[`SCCS_CTL_INTEN];
   assign xtal_en = ctl_q[`SCCS_CTL_XTLEN];
   assign wdt_en = ctl_q[`SCCS_CTL_WDTEN] | failover_q;

   // RC mode halves the raw oscillator so the derived clock has an even duty cycle.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rc_half_q <= 1'b0;
      end
      else if (mode == sccs_pkg::SCCS_MODE_RC && xin_rise)
      begin
         rc_half_q <= ~rc_half_q;
      end
   end
   assign xtal_lvl = (mode == sccs_pkg::SCCS_MODE_RC) ? rc_half_q : xin_lvl;

   // Level of the source now driving the root clock.
   always_comb
   begin
      case (cur_q)
         sccs_pkg::SCCS_SRC_XTAL: root_d = xtal_lvl;
         sccs_pkg::SCCS_SRC_WDT: root_d = wdt_lvl;
         default: root_d = ipo_lvl;
      endcase
   end

   // Changeover only while the root clock and the current source are both low, so no phase is cut.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cur_q <= sccs_pkg::SCCS_SRC_IPO;
         root_q <= 1'b0;
      end
      else if (cur_q != tgt_src && !root_q && !root_d)
      begin
         cur_q <= tgt_src;
         root_q <= 1'b0;
      end
      else
      begin
         root_q <= root_d;
      end
   end
   assign root_rise = root_d & ~root_q;

   // Divider: settings of 0 and 1 pass the root clock, larger ones stretch the period.
   assign div_cnt_d = (div_cnt_q >= div_q - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         div_cnt_q <= 8'h00;
         sys_clk_q <= 1'b0;
      end
      else if (div_q <= 8'h01)
      begin
         div_cnt_q <= 8'h00;
         sys_clk_q <= root_q;
      end
      else if (root_rise)
      begin
         div_cnt_q <= div_cnt_d;
         sys_clk_q <= (div_cnt_d < (div_q >> 1));
      end
   end
   assign sys_clk_o = sys_clk_q;
   // Rising edge of the system clock from a registered copy of its previous level.
   assign sys_rise = sys_clk_q & ~sys_prev_q;

   // Period measure of the system clock; a long period marks it as slower than the flash limit.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         per_cnt_q <= 8'h00;
         slow_q <= 1'b0;
         flash_pd_q <= 1'b0;
         sys_prev_q <= 1'b0;
      end
      else
      begin
         sys_prev_q <= sys_clk_q;
         if (sys_rise)
         begin
            per_cnt_q <= 8'h00;
            slow_q <= (per_cnt_q >= 8'(`SCCS_FLASH_CYC - 1));
         end
         else if (per_cnt_q != 8'hFF)
         begin
            per_cnt_q <= per_cnt_q + 8'h01;
         end
         // Flash sleeps in the low phase delayed by one register clock, so reads after the first high cycle stay valid.
         flash_pd_q <= (slow_q | ctl_q[`SCCS_CTL_FLPEN]) & ~sys_clk_q;
      end
   end
   assign flash_pd = flash_pd_q;

   // Primary failure: too many register clocks without an edge from the programmed source.
   always_comb
   begin
      case (prog_src)
         sccs_pkg::SCCS_SRC_XTAL: prog_rise = xin_rise;
         sccs_pkg::SCCS_SRC_WDT: prog_rise = wdt_rise;
         default: prog_rise = ipo_rise;
      endcase
   end
   assign pf_event = ctl_q[`SCCS_CTL_PRIMARY_FAIL_DETECT_ENABLE] && !wdt_dead_q && !failover_q &&
                     pf_cnt_q == 20'(PRIM_FAIL_CYC - 1);

   // A watchdog primary cannot fail over to itself; a failover ends on the next unlocked control write.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pf_cnt_q <= 20'h00000;
         failover_q <= 1'b0;
      end
      else
      begin
         pf_cnt_q <= (prog_rise || ctl_wr) ? 20'h00000 :
                     (pf_event ? pf_cnt_q : pf_cnt_q + 20'h00001);
         if (ctl_wr && lock_q == sccs_pkg::SCCS_LK_OPEN)
         begin
            failover_q <= 1'b0;
         end
         else if (pf_event && prog_src != sccs_pkg::SCCS_SRC_WDT)
         begin
            failover_q <= 1'b1;
         end
      end
   end

   // Watchdog failure: system clock edges counted between watchdog edges.
   assign wf_event = ctl_q[`SCCS_CTL_WDFEN] && sys_rise && !wdt_dead_q &&
                     wf_cnt_q == 14'(`SCCS_WDT_FAIL_CNT - 1);
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wf_cnt_q <= 14'h0000;
         wdt_dead_q <= 1'b0;
      end
      else if (wdt_rise)
      begin
         wf_cnt_q <= 14'h0000;
         wdt_dead_q <= 1'b0;
      end
      else if (wf_event)
      begin
         wdt_dead_q <= 1'b1;
      end
      else if (sys_rise && !wdt_dead_q)
      begin
         wf_cnt_q <= wf_cnt_q + 14'h0001;
      end
   end

   // Sticky status, write one to clear; a new event in the clearing cycle wins.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         stat_q <= 2'h0;
         mask_q <= 2'h0;
      end
      else
      begin
         stat_q[`SCCS_STAT_PFAIL] <= pf_event | (stat_q[`SCCS_STAT_PFAIL] &
            ~(apb_wr && paddr == `SCCS_ADDR_STAT && pwdata[`SCCS_STAT_PFAIL]));
         stat_q[`SCCS_STAT_WFAIL] <= wf_event | (stat_q[`SCCS_STAT_WFAIL] &
            ~(apb_wr && paddr == `SCCS_ADDR_STAT && pwdata[`SCCS_STAT_WFAIL]));
         if (apb_wr && paddr == `SCCS_ADDR_MASK)
         begin
            mask_q <= pwdata[1:0];
         end
      end
   end
   assign irq = |(stat_q & mask_q);

   // Checks on the clock selection, lock and failure logic.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_rc_halving: assert property (
      mode == sccs_pkg::SCCS_MODE_RC && xin_rise |=> rc_half_q != $past(rc_half_q))
      else $error("RC half clock did not toggle on a raw edge");
   a_xtal_direct: assert property (
      cur_q == sccs_pkg::SCCS_SRC_XTAL && tgt_src == sccs_pkg::SCCS_SRC_XTAL &&
      mode != sccs_pkg::SCCS_MODE_RC |=> root_q == $past(xin_lvl))
      else $error("Crystal root clock does not follow the input pin");
   a_locked_ignore: assert property (
      ctl_wr && lock_q != sccs_pkg::SCCS_LK_OPEN |=> $stable(ctl_q))
      else $error("Control register changed while locked");
   a_write_relock: assert property (
      ctl_wr && lock_q == sccs_pkg::SCCS_LK_OPEN |=>
      lock_q == sccs_pkg::SCCS_LK_LOCKED && ctl_q == $past(pwdata[7:0]))
      else $error("Unlocked write did not apply and relock");
   a_reset_ipo: assert property (
      $fell(sys_rst) |-> cur_q == sccs_pkg::SCCS_SRC_IPO)
      else $error("Precision oscillator not selected after reset");
   a_trim_load: assert property (
      $fell(sys_rst) |-> ipo_trim == $past(opt_trim))
      else $error("Trim not loaded from option bits");
   a_fail_switch: assert property (
      pf_event && prog_src != sccs_pkg::SCCS_SRC_WDT |=>
      failover_q && stat_q[`SCCS_STAT_PFAIL] && tgt_src == sccs_pkg::SCCS_SRC_WDT)
      else $error("Primary failure did not force the watchdog oscillator");
   a_wdt_no_switch: assert property (
      prog_src == sccs_pkg::SCCS_SRC_WDT && !failover_q && !ctl_wr |=> !failover_q)
      else $error("Failover occurred with the watchdog as primary");
   a_wdt_fail_cnt: assert property (
      $rose(wdt_dead_q) |-> $past(wf_cnt_q) == 14'(`SCCS_WDT_FAIL_CNT - 1))
      else $error("Watchdog failure declared at the wrong count");
   a_switch_low: assert property (
      cur_q != $past(cur_q) |-> !$past(root_q) && !root_q)
      else $error("Source changed while the root clock was high");
   a_flash_high: assert property (
      sys_clk_q [*2] |-> !flash_pd_q)
      else $error("Flash powered down during the clock high phase");

   c_failover: cover property (pf_event ##1 failover_q);
   c_wdt_fail: cover property (wf_event);
   c_unlock_write: cover property (ctl_wr && lock_q == sccs_pkg::SCCS_LK_OPEN);
   c_src_switch: cover property ($changed(cur_q));
endmodule : sccs_clock_ctrl

// ### sccs_clock_ctrl_bench.sv
// Self-checking bench for the system clock source control.
// Assumes the APB slave of the design and the external oscillator model beside it.
`timescale 1ns/1ps
`include "sccs_defines.svh"
module sccs_clock_ctrl_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic pready, pslverr, err, xin, sys_clk_o, ipo_en, xtal_en, wdt_en, flash_pd, irq;
   logic ipo_clk = 1'b0, wdt_clk = 1'b0, wdt_run = 1'b1, xfail = 1'b0, opt_lp_n = 1'b1;
   logic [1:0] opt_osc_mode = 2'h3;
   logic [1:0] xtal_drive;
   logic [7:0] opt_trim = 8'h3C;
   logic [7:0] ipo_trim;
   logic sprev = 1'b0, fpd_seen = 1'b0, armed = 1'b0;
   int failures = 0, samples_checked = 0, cycles = 0, n, rises = 0, r0, ph = 0;

   // Clocks; oscillator edges fall on falling clk edges so sampling never races.
   always #2 clk = ~clk;
   always #16 ipo_clk = (ipo_en === 1'b1) ? ~ipo_clk : 1'b0;
   always #24 wdt_clk = (wdt_run && wdt_en === 1'b1) ? ~wdt_clk : 1'b0;

   sccs_clock_ctrl #(.PRIM_FAIL_CYC(200)) sccs_clock_ctrl_i (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .xin(xin), .ipo_clk(ipo_clk),
      .wdt_clk(wdt_clk), .opt_osc_mode(opt_osc_mode), .opt_trim(opt_trim),
      .opt_lp_n(opt_lp_n), .sys_clk_o(sys_clk_o), .ipo_trim(ipo_trim), .ipo_en(ipo_en),
      .xtal_en(xtal_en), .wdt_en(wdt_en), .xtal_drive(xtal_drive), .flash_pd(flash_pd),
      .irq(irq));

   sccs_osc_model #(.HALF_NS(20)) sccs_osc_model_i (.enable(xtal_en), .fail(xfail), .xin(xin));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      if (failures == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // Timeout, sys clock rise count, flash power-down seen and shortest phase watch.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (flash_pd === 1'b1)
         fpd_seen <= 1'b1;
      sprev <= sys_clk_o;
      if (sprev === 1'b0 && sys_clk_o === 1'b1)
         rises <= rises + 1;
      if (sys_rst)
      begin
         ph <= 0;
         armed <= 1'b0;
      end
      else if (sys_clk_o !== sprev)
      begin
         if (armed)
            check(ph >= 1, 1);
         armed <= 1'b1;
         ph <= 0;
      end
      else
         ph <= ph + 1;
      if (cycles == 100000)
      begin
         failures++;
         end_of_test();
      end
   end

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(v, exp);
   endtask : rdc

   // Writes land only after both keys, so this task sends both keys and then the value.
   task automatic ctl_write(input logic [7:0] val);
      apb(1'b1, `SCCS_ADDR_CTL, 32'hE7);
      apb(1'b1, `SCCS_ADDR_CTL, 32'h18);
      apb(1'b1, `SCCS_ADDR_CTL, {24'h0, val});
   endtask : ctl_write

   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   // Cycles between two sys clock rises, after letting a switch settle.
   task automatic period(input int exp);
      int r;
      for (int i = 0; i < 4; i++)
      begin
         if (i == 2)
            fpd_seen = 1'b0;
         r = rises;
         n = 0;
         while (rises == r && n < 4000)
         begin
            @(posedge clk);
            n++;
         end
      end
      check(n, exp);
   endtask : period

   // Main sequence.
   initial
   begin
      do_reset();
      rdc(`SCCS_ADDR_CTL, 32'hA0);
      check(ipo_en, 1'b1);
      rdc(`SCCS_ADDR_DIV, 32'h0);
      rdc(`SCCS_ADDR_TRIM, 32'h3C);
      check(ipo_trim, 8'h3C);
      rdc(`SCCS_ADDR_INFO, 32'h0C);
      rdc(8'h20, 32'h0);
      check(err, 1'b1);
      period(8);
      apb(1'b1, `SCCS_ADDR_CTL, 32'h41);
      rdc(`SCCS_ADDR_CTL, 32'hA0);
      apb(1'b1, `SCCS_ADDR_CTL, 32'hE7);
      apb(1'b1, `SCCS_ADDR_DIV, 32'h0);
      apb(1'b1, `SCCS_ADDR_CTL, 32'h18);
      apb(1'b1, `SCCS_ADDR_CTL, 32'hE1);
      rdc(`SCCS_ADDR_CTL, 32'hE1);
      apb(1'b1, `SCCS_ADDR_CTL, 32'hA0);
      rdc(`SCCS_ADDR_CTL, 32'hE1);
      check(xtal_en, 1'b1);
      period(10);
      check(fpd_seen, 1'b0);
      rdc(`SCCS_ADDR_INFO, 32'h0D);
      apb(1'b1, `SCCS_ADDR_DIV, 32'h4);
      period(40);
      check(fpd_seen, 1'b1);
      rdc(`SCCS_ADDR_INFO, 32'h2D);
      apb(1'b1, `SCCS_ADDR_DIV, 32'h0);
      apb(1'b1, `SCCS_ADDR_TRIM, 32'h5A);
      rdc(`SCCS_ADDR_TRIM, 32'h5A);
      check(ipo_trim, 8'h5A);
      apb(1'b1, `SCCS_ADDR_MASK, 32'h1);
      ctl_write(8'hF1);
      period(10);
      xfail <= 1'b1;
      repeat (150) @(posedge clk);
      check(irq, 1'b0);
      n = 0;
      while (irq !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      check(irq, 1'b1);
      rdc(`SCCS_ADDR_STAT, 32'h1);
      period(12);
      apb(1'b1, `SCCS_ADDR_MASK, 32'h0);
      check(irq, 1'b0);
      apb(1'b1, `SCCS_ADDR_MASK, 32'h1);
      apb(1'b1, `SCCS_ADDR_STAT, 32'h1);
      rdc(`SCCS_ADDR_STAT, 32'h0);
      check(irq, 1'b0);
      xfail <= 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         opt_osc_mode <= m[1:0];
         do_reset();
         check(xtal_drive, m[1:0]);
         rdc(`SCCS_ADDR_INFO, {28'h0, m[1:0], 2'h0});
         if (m == 0)
         begin
            ctl_write(8'hE1);
            period(20);
         end
      end
      opt_lp_n <= 1'b0;
      do_reset();
      rdc(`SCCS_ADDR_CTL, 32'hA4);
      rdc(`SCCS_ADDR_DIV, 32'h8);
      opt_lp_n <= 1'b1;
      do_reset();
      apb(1'b1, `SCCS_ADDR_MASK, 32'h2);
      wdt_run <= 1'b0;
      ctl_write(8'hA8);
      r0 = rises;
      n = 0;
      while (irq !== 1'b1 && n < 80000)
      begin
         @(posedge clk);
         n++;
      end
      check((rises - r0 > 7990) && (rises - r0 < 8010), 1);
      rdc(`SCCS_ADDR_STAT, 32'h2);
      end_of_test();
   end
endmodule : sccs_clock_ctrl_bench

// ### sccs_defines.svh
// Offsets, field positions, reset values and timing counts of the system clock source control.
// Assumes a 250 MHz register clock and an APB slave with byte addresses in paddr[7:0].
`ifndef SCCS_DEFINES_SVH
`define SCCS_DEFINES_SVH

// Register byte offsets.
`define SCCS_ADDR_CTL 8'h00
`define SCCS_ADDR_DIV 8'h04
`define SCCS_ADDR_TRIM 8'h08
`define SCCS_ADDR_STAT 8'h0C
`define SCCS_ADDR_MASK 8'h10
`define SCCS_ADDR_INFO 8'h14

// Oscillator control register fields and unlock keys.
`define SCCS_CTL_INTEN 7
`define SCCS_CTL_XTLEN 6
`define SCCS_CTL_WDTEN 5
`define SCCS_CTL_PRIMARY_FAIL_DETECT_ENABLE 4
`define SCCS_CTL_WDFEN 3
`define SCCS_CTL_FLPEN 2
`define SCCS_CTL_RST 8'hA0
`define SCCS_UNLOCK_1 8'hE7
`define SCCS_UNLOCK_2 8'h18
`define SCCS_SEL_XTAL 2'h1
`define SCCS_SEL_WDT 2'h2

// Divider reset values; the low power value applies when the low power option is chosen.
`define SCCS_DIV_RST 8'h00
`define SCCS_DIV_LP 8'h08

// Status bit positions.
`define SCCS_STAT_PFAIL 0
`define SCCS_STAT_WFAIL 1

// Timing: register clock rate, flash threshold and failure limits.
`define SCCS_CLK_MHZ 250
`define SCCS_FLASH_MHZ 10
`define SCCS_FLASH_CYC ((`SCCS_CLK_MHZ + `SCCS_FLASH_MHZ - 1) / `SCCS_FLASH_MHZ)
`define SCCS_PRIM_FAIL_US 1000
`define SCCS_PRIM_FAIL_CYC (`SCCS_PRIM_FAIL_US * `SCCS_CLK_MHZ)
`define SCCS_WDT_FAIL_CNT 8000

`endif

// ### sccs_edge_sync.sv
// Two flip-flop synchroniser with rising edge detect for one oscillator level.
// Assumes the input is asynchronous to clk and far slower than it.
`timescale 1ns/1ps
module sccs_edge_sync
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic lvl,
   output logic rise
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // The first stage feeds only the second stage, to contain metastability.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Level and one-cycle rising edge pulse.
   assign lvl = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule : sccs_edge_sync

// ### sccs_osc_model.sv
// External timing element on the oscillator input pin: a CMOS-level clock driver.
// Assumes the design enables it through its crystal enable; the bench may make it fail.
`timescale 1ns/1ps
module sccs_osc_model
#(
   parameter int HALF_NS = 20
)
(
   input wire logic enable,
   input wire logic fail,
   output logic xin
);
   initial xin = 1'b0;

   // A stopped or failed driver sits low; the output pin of the pair is left open.
   always
   begin
      #(HALF_NS);
      xin = (enable === 1'b1 && !fail) ? ~xin : 1'b0;
   end
endmodule : sccs_osc_model

// ### sccs_pkg.sv
// Types shared by the system clock source control.
// Assumes sccs_defines.svh supplies all numeric constants.
package sccs_pkg;

   // Clock sources that can drive the system clock.
   typedef enum logic [1:0] {SCCS_SRC_IPO, SCCS_SRC_XTAL, SCCS_SRC_WDT} sccs_src_e;

   // Oscillator modes chosen by option bits, in option encoding order.
   typedef enum logic [1:0] {SCCS_MODE_RC, SCCS_MODE_LOW, SCCS_MODE_MED, SCCS_MODE_HIGH} sccs_mode_e;

   // Unlock sequence of the oscillator control register.
   typedef enum logic [1:0] {SCCS_LK_LOCKED, SCCS_LK_KEY1, SCCS_LK_OPEN} sccs_lock_e;

endpackage : sccs_pkg
